// [pkg/osc_mult_pkg.sv]
// Constants, types and helpers shared by the oscillator trim and multiplier control
package osc_mult_pkg;

    localparam int unsigned CLK_MHZ         = 100;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  FINE_TRIM_IDX   = 8'h9E;
    localparam logic [7:0]  COARSE_TRIM_IDX = 8'hA2;
    localparam logic [7:0]  MULT_CTRL_IDX   = 8'h97;
    localparam int unsigned ADDR_IDX_LSB    = 2;
    localparam int unsigned ADDR_IDX_MSB    = 9;

    // Multiplier control field positions
    localparam int unsigned MC_ENABLE_BIT   = 7;
    localparam int unsigned MC_INIT_BIT     = 6;
    localparam int unsigned MC_LOCKED_BIT   = 5;
    localparam int unsigned MC_SCALE_MSB    = 4;
    localparam int unsigned MC_SCALE_LSB    = 2;
    localparam int unsigned MC_SRC_MSB      = 1;
    localparam int unsigned MC_SRC_LSB      = 0;

    localparam logic [7:0]  MULT_CTRL_RESET = 8'h00;
    localparam int unsigned COARSE_W        = 7;
    localparam int unsigned FINE_W          = 6;

    typedef enum logic [1:0] {
        SRC_EXT,
        SRC_INT_HALF,
        SRC_EXT_HALF,
        SRC_RESERVED
    } mult_src_t;

    // Burst shape of the multiplier pulse stream
    localparam int unsigned BURST_PULSES    = 4;
    localparam int unsigned FAST_GAP_NS     = 20;
    localparam int unsigned FAST_GAP_CYCLES =
        ((FAST_GAP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (FAST_GAP_NS * CLK_MHZ + 999) / 1000;

    // Least settle time before the locked flag may rise
    localparam int unsigned LOCK_TIME_NS    = 10000;
    localparam int unsigned LOCK_CYCLES     =
        ((LOCK_TIME_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;

    // Scale is 2/N; codes 0..2 give N=2, i.e. factor one
    function automatic logic [2:0] scale_den(input logic [2:0] code);
        logic [2:0] den;
        den = (code < 3'h2) ? 3'h2 : code;
        return den;
    endfunction : scale_den

endpackage : osc_mult_pkg

// [rtl/mult_pulse_gen.sv]
// Multiplier pulse stream: four fast pulses per input edge, kept 2 of every N
`timescale 1ns/1ps
`default_nettype none
module mult_pulse_gen
    import osc_mult_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = FAST_GAP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       src_edge,
    input  wire logic       run,
    input  wire logic [2:0] scale_code,
    output logic            pulse_out
);

    localparam int unsigned GW = (GAP_CYCLES < 2) ? 1 : $clog2(GAP_CYCLES);

    logic [2:0]    left_ff;
    logic [2:0]    nxt_left;
    logic [GW-1:0] gap_ff;
    logic [GW-1:0] nxt_gap;
    logic [2:0]    phase_ff;
    logic [2:0]    nxt_phase;
    logic          pulse_ff;
    logic          nxt_pulse;
    logic [2:0]    den;

    always_comb begin
        den       = scale_den(scale_code);
        nxt_left  = left_ff;
        nxt_gap   = gap_ff;
        nxt_phase = phase_ff;
        nxt_pulse = 1'b0;
        if (!run) begin
            nxt_left  = 3'h0;
            nxt_gap   = '0;
            nxt_phase = 3'h0;
        end else if (src_edge) begin
            // Each input edge starts a fresh burst of fast pulses
            nxt_left = 3'(BURST_PULSES);
            nxt_gap  = '0;
        end else if (left_ff != 3'h0) begin
            if (gap_ff == '0) begin
                nxt_left  = left_ff - 3'h1;
                nxt_gap   = GW'(GAP_CYCLES - 1);
                // Two of every N fast pulses pass: factor 2/N
                nxt_pulse = (phase_ff < 3'h2);
                nxt_phase = (phase_ff >= den - 3'h1) ? 3'h0 : phase_ff + 3'h1;
            end else begin
                nxt_gap = gap_ff - GW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_ff  <= 3'h0;
            gap_ff   <= '0;
            phase_ff <= 3'h0;
            pulse_ff <= 1'b0;
        end else begin
            left_ff  <= nxt_left;
            gap_ff   <= nxt_gap;
            phase_ff <= nxt_phase;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse_out = pulse_ff;

    a_burst_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (src_edge && run) ##1 (!src_edge && run)[*8] |-> (left_ff == 3'h0))
        else $error("burst did not end after four fast pulses");

    a_pulse_needs_run: assert property (@(posedge clk) disable iff (sys_rst)
        pulse_out |-> $past(run))
        else $error("pulse emitted while multiplier not running");

endmodule : mult_pulse_gen
`default_nettype wire

// [rtl/osc_trim_and_clock_multiplier.sv]
// Oscillator trim registers and clock multiplier control behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module osc_trim_and_clock_multiplier
    import osc_mult_pkg::*;
#(
    parameter int unsigned LOCK_WAIT  = LOCK_CYCLES,
    parameter int unsigned GAP_CYCLES = FAST_GAP_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Factory calibration words from the fuse block
    input  wire logic [COARSE_W-1:0] cal_coarse,
    input  wire logic [FINE_W-1:0]   cal_fine,
    // Raw oscillator clocks, asynchronous to clk
    input  wire logic                ext_osc_in,
    input  wire logic                int_osc_in,
    // Trim words to the oscillator
    output logic [COARSE_W-1:0]      coarse_trim,
    output logic [FINE_W-1:0]        fine_trim,
    // Multiplier status and pulse stream
    output logic                     mult_enable,
    output logic                     mult_locked,
    output logic                     mult_clk_pulse
);

    localparam int unsigned LW = $clog2(LOCK_WAIT + 1);

    // ---------------- Oscillator inputs: sync, edge, halving
    logic      ext_s1_ff;
    logic      ext_s2_ff;
    logic      ext_prev_ff;
    logic      int_s1_ff;
    logic      int_s2_ff;
    logic      int_prev_ff;
    logic      ext_half_ff;
    logic      int_half_ff;
    logic      nxt_ext_half;
    logic      nxt_int_half;
    logic      ext_rise;
    logic      int_rise;
    logic      src_edge;
    mult_src_t src_sel;

    always_comb begin
        ext_rise     = ext_s2_ff & ~ext_prev_ff;
        int_rise     = int_s2_ff & ~int_prev_ff;
        nxt_ext_half = ext_rise ? ~ext_half_ff : ext_half_ff;
        nxt_int_half = int_rise ? ~int_half_ff : int_half_ff;
        // Halved sources see every second rising edge
        unique case (src_sel)
            SRC_EXT:      src_edge = ext_rise;
            SRC_INT_HALF: src_edge = int_rise & ~int_half_ff;
            SRC_EXT_HALF: src_edge = ext_rise & ~ext_half_ff;
            SRC_RESERVED: src_edge = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_s1_ff   <= 1'b0;
            ext_s2_ff   <= 1'b0;
            ext_prev_ff <= 1'b0;
            int_s1_ff   <= 1'b0;
            int_s2_ff   <= 1'b0;
            int_prev_ff <= 1'b0;
            ext_half_ff <= 1'b0;
            int_half_ff <= 1'b0;
        end else begin
            ext_s1_ff   <= ext_osc_in;
            ext_s2_ff   <= ext_s1_ff;
            ext_prev_ff <= ext_s2_ff;
            int_s1_ff   <= int_osc_in;
            int_s2_ff   <= int_s1_ff;
            int_prev_ff <= int_s2_ff;
            ext_half_ff <= nxt_ext_half;
            int_half_ff <= nxt_int_half;
        end
    end

    // ---------------- Bus address phase capture
    logic       ap_valid;
    logic       ap_hit;
    logic [7:0] ap_idx;
    logic       wr_ph_ff;
    logic       nxt_wr_ph;
    logic [7:0] wr_idx_ff;
    logic [7:0] nxt_wr_idx;
    logic [7:0] wbyte;
    logic       wr_fine;
    logic       wr_coarse;
    logic       wr_ctrl;

    always_comb begin
        ap_valid   = hsel & htrans[1] & hready;
        ap_idx     = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
        ap_hit     = (haddr[31:ADDR_IDX_MSB+1] == '0) && (haddr[1:0] == 2'b00);
        nxt_wr_ph  = ap_valid & hwrite & ap_hit;
        nxt_wr_idx = ap_valid ? ap_idx : wr_idx_ff;
        // Narrow writes land in lane zero of an aligned word
        wbyte      = hwdata[7:0];
        wr_fine    = wr_ph_ff && (wr_idx_ff == FINE_TRIM_IDX);
        wr_coarse  = wr_ph_ff && (wr_idx_ff == COARSE_TRIM_IDX);
        wr_ctrl    = wr_ph_ff && (wr_idx_ff == MULT_CTRL_IDX);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ph_ff  <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_ph_ff  <= nxt_wr_ph;
            wr_idx_ff <= nxt_wr_idx;
        end
    end

    // ---------------- Trim, control and lock state
    logic [COARSE_W-1:0] coarse_ff;
    logic [COARSE_W-1:0] nxt_coarse;
    logic [FINE_W-1:0]   fine_ff;
    logic [FINE_W-1:0]   nxt_fine;
    logic                en_ff;
    logic                nxt_en;
    logic                init_ff;
    logic                nxt_init;
    logic [2:0]          scale_ff;
    logic [2:0]          nxt_scale;
    logic [1:0]          src_ff;
    logic [1:0]          nxt_src;
    logic                locking_ff;
    logic                nxt_locking;
    logic                locked_ff;
    logic                nxt_locked;
    logic [LW-1:0]       lock_cnt_ff;
    logic [LW-1:0]       nxt_lock_cnt;

    always_comb begin
        nxt_coarse   = coarse_ff;
        nxt_fine     = fine_ff;
        nxt_en       = en_ff;
        nxt_init     = init_ff;
        nxt_scale    = scale_ff;
        nxt_src      = src_ff;
        nxt_locking  = locking_ff;
        nxt_locked   = locked_ff;
        nxt_lock_cnt = lock_cnt_ff;
        // Upper bits of the trim writes are dropped
        if (wr_coarse) begin
            nxt_coarse = wbyte[COARSE_W-1:0];
        end
        if (wr_fine) begin
            nxt_fine = wbyte[FINE_W-1:0];
        end
        if (locking_ff) begin
            if (lock_cnt_ff == '0) begin
                nxt_locking = 1'b0;
                nxt_locked  = 1'b1;
            end else begin
                nxt_lock_cnt = lock_cnt_ff - LW'(1);
            end
        end
        if (wr_ctrl) begin
            nxt_en    = wbyte[MC_ENABLE_BIT];
            nxt_init  = wbyte[MC_INIT_BIT];
            nxt_scale = wbyte[MC_SCALE_MSB:MC_SCALE_LSB];
            nxt_src   = wbyte[MC_SRC_MSB:MC_SRC_LSB];
            // A rewrite keeps a held lock only with enable set and init clear; init restarts it only if already enabled
            nxt_locked   = locked_ff & wbyte[MC_ENABLE_BIT] & ~wbyte[MC_INIT_BIT];
            nxt_locking  = 1'b0;
            nxt_lock_cnt = '0;
            if (wbyte == 8'h00) begin
                nxt_locked = 1'b0;
            end else if (en_ff && wbyte[MC_ENABLE_BIT] && wbyte[MC_INIT_BIT]) begin
                nxt_locking  = 1'b1;
                nxt_lock_cnt = LW'(LOCK_WAIT - 1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Calibration words are caught while reset is held
            coarse_ff   <= cal_coarse;
            fine_ff     <= cal_fine;
            en_ff       <= MULT_CTRL_RESET[MC_ENABLE_BIT];
            init_ff     <= MULT_CTRL_RESET[MC_INIT_BIT];
            scale_ff    <= MULT_CTRL_RESET[MC_SCALE_MSB:MC_SCALE_LSB];
            src_ff      <= MULT_CTRL_RESET[MC_SRC_MSB:MC_SRC_LSB];
            locking_ff  <= 1'b0;
            locked_ff   <= 1'b0;
            lock_cnt_ff <= '0;
        end else begin
            coarse_ff   <= nxt_coarse;
            fine_ff     <= nxt_fine;
            en_ff       <= nxt_en;
            init_ff     <= nxt_init;
            scale_ff    <= nxt_scale;
            src_ff      <= nxt_src;
            locking_ff  <= nxt_locking;
            locked_ff   <= nxt_locked;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    // ---------------- Read data, taken from next values so a write reads back at once
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;

    always_comb begin
        nxt_hrdata = hrdata_ff;
        if (ap_valid && !hwrite) begin
            nxt_hrdata = 32'h0000_0000;
            if (ap_hit) begin
                unique case (ap_idx)
                    COARSE_TRIM_IDX: nxt_hrdata[COARSE_W-1:0] = nxt_coarse;
                    FINE_TRIM_IDX:   nxt_hrdata[FINE_W-1:0] = nxt_fine;
                    MULT_CTRL_IDX:   nxt_hrdata[7:0] = {nxt_en, nxt_init, nxt_locked,
                                                        nxt_scale, nxt_src};
                    default:         nxt_hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Zero wait states; the slave never stalls or errors
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_ff;
    assign coarse_trim = coarse_ff;
    assign fine_trim   = fine_ff;
    assign mult_enable = en_ff;
    assign mult_locked = locked_ff;
    assign src_sel     = mult_src_t'(src_ff);

    // Pulses only flow once locked
    mult_pulse_gen #(
        .GAP_CYCLES (GAP_CYCLES)
    ) i_mult_pulse_gen (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .src_edge   (src_edge),
        .run        (locked_ff & en_ff),
        .scale_code (scale_ff),
        .pulse_out  (mult_clk_pulse)
    );

    // ---------------- Checks
    logic          rd_ph_ff;
    logic [7:0]    rd_idx_ff;
    // Cycles in the current lock sequence; a restarting write starts over
    logic [LW-1:0] lock_age_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ph_ff    <= 1'b0;
            rd_idx_ff   <= 8'h00;
            lock_age_ff <= '0;
        end else begin
            rd_ph_ff    <= ap_valid & ~hwrite & ap_hit;
            rd_idx_ff   <= ap_idx;
            lock_age_ff <= (locking_ff && !wr_ctrl) ? lock_age_ff + LW'(1) : LW'(0);
        end
    end

    a_coarse_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_ph_ff && rd_idx_ff == COARSE_TRIM_IDX) |-> (hrdata[31:7] == '0))
        else $error("coarse trim read shows upper bits set");

    a_fine_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_ph_ff && rd_idx_ff == FINE_TRIM_IDX) |-> (hrdata[31:6] == '0))
        else $error("fine trim read shows upper bits set");

    a_cal_loaded: assert property (@(posedge clk)
        $fell(sys_rst) |-> (coarse_trim == $past(cal_coarse)) && (fine_trim == $past(cal_fine)))
        else $error("trim words not loaded from calibration at reset");

    a_ctrl_reset_zero: assert property (@(posedge clk)
        $fell(sys_rst) |-> !mult_enable && !mult_locked && scale_ff == 3'h0 && src_ff == 2'h0)
        else $error("multiplier control not zero after reset");

    a_zero_stops: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_ctrl && wbyte == 8'h00) |=> !mult_locked ##1 !mult_clk_pulse)
        else $error("zero write did not stop the multiplier");

    a_lock_needs_init: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(mult_locked) |-> $past(locking_ff) && mult_enable)
        else $error("locked flag rose without a lock sequence");

    a_lock_bounded: assert property (@(posedge clk) disable iff (sys_rst)
        locking_ff |-> (lock_age_ff < LW'(LOCK_WAIT)))
        else $error("lock sequence did not finish in time");

endmodule : osc_trim_and_clock_multiplier
`default_nettype wire

// [tb/osc_trim_and_clock_multiplier_test.sv]
// Register-level testbench for the oscillator trim and clock multiplier block
`timescale 1ns/1ps
`default_nettype none
module osc_trim_and_clock_multiplier_test
    import osc_mult_pkg::*;
;
    logic                clk;
    logic                sys_rst;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    wire logic           hreadyout;
    logic                hresp;
    logic [31:0]         hrdata;
    logic [COARSE_W-1:0] cal_coarse;
    logic [FINE_W-1:0]   cal_fine;
    logic                ext_osc;
    logic                int_osc;
    logic [COARSE_W-1:0] coarse_trim;
    logic [FINE_W-1:0]   fine_trim;
    logic                mult_enable;
    logic                mult_locked;
    logic                mult_clk_pulse;
    int                  miscompares;
    int                  samples_checked;
    int                  pulse_cnt;
    logic [31:0]         rd;

    osc_trim_and_clock_multiplier #(.LOCK_WAIT(8), .GAP_CYCLES(2)) i_osc_trim_and_clock_multiplier (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .hsel           (hsel),
        .haddr          (haddr),
        .htrans         (htrans),
        .hwrite         (hwrite),
        .hsize          (hsize),
        .hwdata         (hwdata),
        .hready         (hreadyout),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .hrdata         (hrdata),
        .cal_coarse     (cal_coarse),
        .cal_fine       (cal_fine),
        .ext_osc_in     (ext_osc),
        .int_osc_in     (int_osc),
        .coarse_trim    (coarse_trim),
        .fine_trim      (fine_trim),
        .mult_enable    (mult_enable),
        .mult_locked    (mult_locked),
        .mult_clk_pulse (mult_clk_pulse)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mult_clk_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Master holds each phase until hready is sampled high; only the watchdog ends a wait
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] data);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        data = hrdata;
        hsel <= 1'b0;
    endtask : ahb

    // One slow high/low period per step; only the counted clocks toggle
    task automatic osc_edges(input int ne, input int ni);
        for (int i = 0; i < ((ne > ni) ? ne : ni); i++) begin
            @(posedge clk);
            ext_osc <= (i < ne);
            int_osc <= (i < ni);
            repeat (20) @(posedge clk);
            ext_osc <= 1'b0;
            int_osc <= 1'b0;
            repeat (19) @(posedge clk);
        end
        repeat (20) @(posedge clk);
    endtask : osc_edges

    task automatic configure(input logic [1:0] src, input logic [2:0] scale);
        logic [7:0] cfg;
        int         n;
        cfg = {3'b000, scale, src};
        ahb(1'b1, MULT_CTRL_IDX, 32'h0000_0000, rd);
        // Flag settles after the data phase edge
        @(negedge clk);
        check("locked after zero write", {31'h0, mult_locked}, 32'h0);
        ahb(1'b1, MULT_CTRL_IDX, {30'h0, src}, rd);
        ahb(1'b1, MULT_CTRL_IDX, {24'h00_0000, cfg}, rd);
        ahb(1'b1, MULT_CTRL_IDX, {24'h00_0000, cfg | 8'h80}, rd);
        repeat (501) @(posedge clk);
        check("enable level", {31'h0, mult_enable}, 32'h1);
        check("no lock without init", {31'h0, mult_locked}, 32'h0);
        ahb(1'b1, MULT_CTRL_IDX, {24'h00_0000, cfg | 8'hC0}, rd);
        ahb(1'b0, MULT_CTRL_IDX, 32'h0, rd);
        check("locked too early", {31'h0, rd[5]}, 32'h0);
        n = 0;
        while (rd[5] !== 1'b1 && n < 20) begin
            ahb(1'b0, MULT_CTRL_IDX, 32'h0, rd);
            n++;
        end
        check("control after lock", rd, {24'h00_0000, cfg | 8'hE0});
    endtask : configure

    // Each slot: source, scale code, ext edges, int edges, expected pulses
    task automatic run_mult(input logic [1:0] src, input logic [2:0] scale,
                            input int ne, input int ni, input int exp);
        int base;
        configure(src, scale);
        base = pulse_cnt;
        osc_edges(ne, ni);
        check("pulse count", 32'(pulse_cnt - base), 32'(exp));
    endtask : run_mult

    initial begin
        int den;
        int base;
        sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        cal_coarse = 7'h55; cal_fine = 6'h2A; ext_osc = 1'b0; int_osc = 1'b0;
        miscompares = 0; samples_checked = 0; pulse_cnt = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        ahb(1'b0, COARSE_TRIM_IDX, 32'h0, rd);
        check("coarse reset", rd, 32'h0000_0055);
        check("coarse port reset", {25'h0, coarse_trim}, 32'h0000_0055);
        ahb(1'b0, FINE_TRIM_IDX, 32'h0, rd);
        check("fine reset", rd, 32'h0000_002A);
        ahb(1'b0, MULT_CTRL_IDX, 32'h0, rd);
        check("control reset", rd, 32'h0000_0000);
        ahb(1'b1, COARSE_TRIM_IDX, 32'hFFFF_FFFF, rd);
        ahb(1'b0, COARSE_TRIM_IDX, 32'h0, rd);
        check("coarse all ones", rd, 32'h0000_007F);
        check("coarse port fastest", {25'h0, coarse_trim}, 32'h0000_007F);
        ahb(1'b1, COARSE_TRIM_IDX, 32'h0000_0000, rd);
        @(negedge clk);
        check("coarse port slowest", {25'h0, coarse_trim}, 32'h0000_0000);
        ahb(1'b1, FINE_TRIM_IDX, 32'h0000_00FF, rd);
        ahb(1'b0, FINE_TRIM_IDX, 32'h0, rd);
        check("fine all ones", rd, 32'h0000_003F);
        check("fine port", {26'h0, fine_trim}, 32'h0000_003F);
        ahb(1'b1, COARSE_TRIM_IDX + 8'h01, 32'h0000_0011, rd);
        ahb(1'b0, COARSE_TRIM_IDX + 8'h01, 32'h0, rd);
        check("unmapped read", rd, 32'h0000_0000);
        check("unmapped response", {31'h0, hresp}, 32'h0);
        ahb(1'b0, COARSE_TRIM_IDX, 32'h0, rd);
        check("coarse after unmapped write", rd, 32'h0000_0000);
        // Over den edges a 2-of-den gate passes eight of 4*den pulses
        for (int c = 0; c < 8; c++) begin
            den = (c < 2) ? 2 : c;
            run_mult(2'd0, 3'(c), den, 3, 8);
        end
        run_mult(2'd1, 3'd6, 3, 12, 8);
        run_mult(2'd2, 3'd3, 6, 3, 8);
        run_mult(2'd3, 3'd0, 4, 4, 0);
        configure(2'd0, 3'd0);
        ahb(1'b1, MULT_CTRL_IDX, 32'h0000_0000, rd);
        ahb(1'b0, MULT_CTRL_IDX, 32'h0, rd);
        check("control after stop", rd, 32'h0000_0000);
        check("enable after stop", {31'h0, mult_enable}, 32'h0);
        base = pulse_cnt;
        osc_edges(3, 3);
        check("pulses after stop", 32'(pulse_cnt - base), 32'h0);
        // Second reset in mid-run reloads fresh calibration
        @(posedge clk);
        cal_coarse <= 7'h12;
        cal_fine   <= 6'h21;
        sys_rst    <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        ahb(1'b0, FINE_TRIM_IDX, 32'h0, rd);
        check("fine second reset", rd, 32'h0000_0021);
        check("coarse second reset", {25'h0, coarse_trim}, 32'h0000_0012);
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule : osc_trim_and_clock_multiplier_test
`default_nettype wire
